// ===== design/addr_io_port_map.vh
// Register indices, field positions, reset values and mode codes of the address-capable I/O port
`ifndef ADDR_IO_PORT_MAP_VH
`define ADDR_IO_PORT_MAP_VH

// Bus widths
`define PORT_W            8
`define PADDR_W           18
`define PDATA_W           32
`define PSTRB_W           4

// Register indices; byte address is four times the index
`define IDX_W             16
`define IDX_PIN_DIRECTION 16'hfeba
`define IDX_PIN_LEVEL     16'hff5a
`define IDX_OUTPUT_LATCH  16'hff6a
`define IDX_PULLUP_CTRL   16'hff71
`define IDX_STANDBY_CTRL  16'hff3f

// Reset values
`define RST_PIN_DIRECTION 8'h00
`define RST_OUTPUT_LATCH  8'h00
`define RST_PULLUP_CTRL   8'h00
`define RST_STANDBY_CTRL  8'h00

// Value returned when the write-only direction register is read
`define DIR_READ_VALUE    8'h00

// Standby control fields
`define STBY_HOLD_BIT     0

// Operating mode codes
`define MODE_W            3
`define MODE_4            3'h4
`define MODE_5            3'h5
`define MODE_6            3'h6
`define MODE_7            3'h7

`endif

// ===== design/pin_sync2.v
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
    parameter WIDTH = 9
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    input  wire             ce,
    // Levels
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // The first stage feeds only the second stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else if (ce) begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // pin_sync2

`default_nettype wire

// ===== design/pin_function_mux.v
// Per-pin function select: general output, address output or input, and pull-up gating
`timescale 1ns/1ps
`default_nettype none
`include "addr_io_port_map.vh"

module pin_function_mux (
    // Chip state
    input  wire [`MODE_W-1:0] op_mode,
    input  wire               sw_standby,
    input  wire               hw_standby,
    input  wire               standby_output_hold,
    // Port registers
    input  wire [7:0]         pin_direction,
    input  wire [7:0]         output_latch,
    input  wire [7:0]         pullup_control,
    // Address sources
    input  wire [7:0]         addr_live,
    input  wire [7:0]         addr_held,
    // Next pin state
    output reg  [7:0]         drive_d,
    output reg  [7:0]         oe_d,
    output reg  [7:0]         pullup_d
);

    reg [7:0] addr_pins;
    reg [7:0] gen_pins;
    reg [7:0] addr_src;
    reg       addr_drive_ok;

    always @* begin
        addr_pins     = 8'h00;
        gen_pins      = 8'h00;
        pullup_d      = 8'h00;
        // Address pins freeze on the held value in software standby, or float
        addr_src      = sw_standby ? addr_held : addr_live;
        addr_drive_ok = !sw_standby || standby_output_hold;   // R13
        case (op_mode)
            `MODE_7: begin
                gen_pins = pin_direction;                      // R03
                pullup_d = ~pin_direction & pullup_control;    // R10
            end
            `MODE_6: begin
                addr_pins = pin_direction;                     // R04
                pullup_d  = ~pin_direction & pullup_control;   // R10
            end
            `MODE_4, `MODE_5: begin
                addr_pins = 8'hff;                             // R05
                pullup_d  = 8'h00;                             // R11
            end
            default: begin
                addr_pins = 8'h00;
            end
        endcase
        // Address bits come from the bus controller, never the latch
        drive_d = (addr_pins & addr_src) | (gen_pins & output_latch);      // R14
        oe_d    = gen_pins | (addr_drive_ok ? addr_pins : 8'h00);
        if (hw_standby) begin
            oe_d     = 8'h00;
            pullup_d = 8'h00;
        end
    end

endmodule // pin_function_mux

`default_nettype wire

// ===== design/addr_io_port.v
// Address-capable 8-bit I/O port with APB register access
//
// Contract
// R01: Direction register eight bits, reads undefined
// R02: Direction cleared at power-on, hardware standby
// R03: Mode 7: direction one drives latch
// R04: Mode 6: direction one drives address
// R05: Modes 4, 5: all pins address outputs
// R06: Output latch read/write, cleared, retained otherwise
// R07: Pin level register read-only, writes ignored
// R08: Level read: latch if output, else pin
// R09: After reset level shows pins; retained otherwise
// R10: Pull-up only when input and enabled
// R11: Modes 4, 5 keep all pull-ups off
// R12: Pull-up control read/write, cleared, retained otherwise
// R13: Standby hold bit keeps or floats address
// R14: Address pins driven from bus controller address
`timescale 1ns/1ps
`default_nettype none
`include "addr_io_port_map.vh"

module addr_io_port (
    // Clock, reset, clock enable
    input  wire                 pclk,
    input  wire                 presetn,
    input  wire                 ce,
    // APB slave
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [`PADDR_W-1:0]  paddr,
    input  wire [`PDATA_W-1:0]  pwdata,
    input  wire [`PSTRB_W-1:0]  pstrb,
    output wire                 pready,
    output reg  [`PDATA_W-1:0]  prdata,
    output reg                  pslverr,
    // Chip state
    input  wire [`MODE_W-1:0]   op_mode,
    input  wire                 sw_standby,
    input  wire                 hw_standby_n,
    input  wire [7:0]           addr_in,
    // Port pins
    input  wire [7:0]           pin_in,
    output reg  [7:0]           pin_out,
    output reg  [7:0]           pin_oe,
    output reg  [7:0]           pullup_en
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function hit;
        input [`PADDR_W-1:0] addr;
        input [`IDX_W-1:0]   idx;
        begin
            hit = (addr[`PADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
        end
    endfunction

    function mapped;
        input [`PADDR_W-1:0] addr;
        begin
            mapped = hit(addr, `IDX_PIN_DIRECTION) || hit(addr, `IDX_PIN_LEVEL) ||
                     hit(addr, `IDX_OUTPUT_LATCH)  || hit(addr, `IDX_PULLUP_CTRL) ||
                     hit(addr, `IDX_STANDBY_CTRL);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin and standby synchronisers

    wire [8:0] sync_bus;
    wire [7:0] pin_sync;
    wire       hw_standby;

    pin_sync2 #(
        .WIDTH    (9)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .async_in ({~hw_standby_n, pin_in}),
        .sync_out (sync_bus)
    );

    assign pin_sync   = sync_bus[7:0];
    assign hw_standby = sync_bus[8];

    ////////////////////////////////////////////////////////////////////////////
    // APB handshake

    // Read data must be captured before the access may complete. With a running
    // clock enable that happens in the setup cycle and no wait state is added;
    // a setup edge lost to a low enable costs one wait state, never stale data.
    reg  rd_valid_q;
    wire capture   = psel && !rd_valid_q;
    wire access_ph = psel && penable && ce && rd_valid_q;
    wire wr_en     = access_ph && pwrite && pstrb[0] && !hw_standby;

    assign pready = ce && rd_valid_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_valid_q <= 1'b0;
        end else if (ce) begin
            if (access_ph) begin
                rd_valid_q <= 1'b0;
            end else if (capture) begin
                rd_valid_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port registers

    reg [7:0] pin_direction_q;
    reg [7:0] output_latch_q;
    reg [7:0] pullup_control_q;
    reg [7:0] standby_control_q;
    reg [7:0] addr_hold_q;

    // Manual reset and software standby have no path here, so contents survive them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_direction_q   <= `RST_PIN_DIRECTION;   // R02
            output_latch_q    <= `RST_OUTPUT_LATCH;    // R06
            pullup_control_q  <= `RST_PULLUP_CTRL;     // R12
            standby_control_q <= `RST_STANDBY_CTRL;
        end else if (ce) begin
            if (hw_standby) begin
                pin_direction_q  <= `RST_PIN_DIRECTION;   // R02
                output_latch_q   <= `RST_OUTPUT_LATCH;    // R06
                pullup_control_q <= `RST_PULLUP_CTRL;     // R12
            end else if (wr_en) begin
                if (hit(paddr, `IDX_PIN_DIRECTION)) begin
                    pin_direction_q <= pwdata[7:0];       // R01
                end
                if (hit(paddr, `IDX_OUTPUT_LATCH)) begin
                    output_latch_q <= pwdata[7:0];        // R06
                end
                if (hit(paddr, `IDX_PULLUP_CTRL)) begin
                    pullup_control_q <= pwdata[7:0];      // R12
                end
                if (hit(paddr, `IDX_STANDBY_CTRL)) begin
                    standby_control_q <= pwdata[7:0];
                end
            end
        end
    end

    // Last live address before standby, reused while held
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_hold_q <= 8'h00;
        end else if (ce && !sw_standby) begin
            addr_hold_q <= addr_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    reg  [7:0] rdata_d;
    wire [7:0] level_view = (pin_direction_q & output_latch_q) | (~pin_direction_q & pin_sync);   // R08 R09

    always @* begin
        rdata_d = 8'h00;
        if (hit(paddr, `IDX_PIN_DIRECTION)) begin
            rdata_d = `DIR_READ_VALUE;           // R01
        end else if (hit(paddr, `IDX_PIN_LEVEL)) begin
            rdata_d = level_view;                // R08
        end else if (hit(paddr, `IDX_OUTPUT_LATCH)) begin
            rdata_d = output_latch_q;
        end else if (hit(paddr, `IDX_PULLUP_CTRL)) begin
            rdata_d = pullup_control_q;
        end else if (hit(paddr, `IDX_STANDBY_CTRL)) begin
            rdata_d = standby_control_q;
        end
    end

    // Read data and error are captured once per transfer and stand through the access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= {`PDATA_W{1'b0}};
            pslverr <= 1'b0;
        end else if (ce && capture) begin
            prdata  <= {{(`PDATA_W-8){1'b0}}, (pwrite ? 8'h00 : rdata_d)};
            // Writes to the level register are dropped silently, not flagged
            pslverr <= !mapped(paddr);           // R07
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive

    wire [7:0] drive_d;
    wire [7:0] oe_d;
    wire [7:0] pullup_d;

    pin_function_mux u_mux (
        .op_mode             (op_mode),
        .sw_standby          (sw_standby),
        .hw_standby          (hw_standby),
        .standby_output_hold (standby_control_q[`STBY_HOLD_BIT]),
        .pin_direction       (pin_direction_q),
        .output_latch        (output_latch_q),
        .pullup_control      (pullup_control_q),
        .addr_live           (addr_in),
        .addr_held           (addr_hold_q),
        .drive_d             (drive_d),
        .oe_d                (oe_d),
        .pullup_d            (pullup_d)
    );

    // Registered pins add one cycle after a register write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out   <= 8'h00;
            pin_oe    <= 8'h00;
            pullup_en <= 8'h00;
        end else if (ce) begin
            pin_out   <= drive_d;                // R03 R04 R05 R14
            pin_oe    <= oe_d;                   // R13
            pullup_en <= pullup_d;               // R10 R11
        end
    end

endmodule // addr_io_port

`default_nettype wire

// ===== verification/addr_io_port_properties.sv
// Port-level assertions for the address-capable I/O port
`timescale 1ns/1ps
`default_nettype none

module addr_io_port_properties (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Chip state and pins
    input wire logic [2:0]  op_mode,
    input wire logic        sw_standby,
    input wire logic        hw_standby_n,
    input wire logic [7:0]  addr_in,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe,
    input wire logic [7:0]  pullup_en
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire mapped = paddr inside {18'h3fae8, 18'h3fd68, 18'h3fda8, 18'h3fdc4, 18'h3fcfc};
    wire m45 = op_mode == 3'h4 || op_mode == 3'h5;
    sequence s_setup;
        psel && !penable && ce;
    endsequence
    // Five cycles let the standby synchroniser settle after hw_standby_n rises
    sequence s_addr_run;
        (m45 && !sw_standby && hw_standby_n && ce) [*5];
    endsequence
    a_dir_read_zero: assert property (s_setup ##0 (!pwrite && paddr == 18'h3fae8) |=> prdata == 0)
        else $error("direction read not zero");
    a_unmapped_err: assert property (s_setup ##0 !mapped |=> pslverr)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (s_setup ##0 mapped |=> !pslverr)
        else $error("mapped access flagged error");
    a_upper_zero: assert property (psel && penable |-> prdata[31:8] == 0)
        else $error("read data upper bits set");
    a_addr_mode45: assert property (s_addr_run |=> pin_oe == 8'hff && pin_out == $past(addr_in))
        else $error("address mode pins wrong");
    a_pull45_off: assert property (m45 && ce |=> pullup_en == 8'h00)
        else $error("pull-up on in address mode");
    a_pull_input: assert property ((pullup_en & pin_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    a_hw_off: assert property ((!hw_standby_n && ce) [*4] |=> pin_oe == 8'h00 && pullup_en == 8'h00)
        else $error("pins active in hardware standby");
endmodule // addr_io_port_properties

bind addr_io_port addr_io_port_properties i_addr_io_port_properties (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .prdata, .pslverr, .op_mode, .sw_standby, .hw_standby_n, .addr_in, .pin_out, .pin_oe,
    .pullup_en);
`default_nettype wire

// ===== verification/ext_pins.sv
// Board-side model of the port pins: external drivers, pull-ups, floating lines
`timescale 1ns/1ps
`default_nettype none

module ext_pins (
    // Clock
    input wire logic        pclk,
    // Port side
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe,
    input wire logic [7:0]  pullup_en,
    // External drivers
    input wire logic [7:0]  ext_en,
    input wire logic [7:0]  ext_val,
    output logic     [7:0]  pin_in
);
    // Undriven lines wander so a stale value never passes as a real one
    logic [7:0] flt = 8'h55;
    always @(posedge pclk) flt <= ~flt;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & (pullup_en | flt));
endmodule // ext_pins
`default_nettype wire

// ===== verification/addr_io_port_test.sv
// Self-checking bench for the address-capable I/O port
`timescale 1ns/1ps
`default_nettype none
`include "addr_io_port_map.vh"

module addr_io_port_test;
    typedef struct packed {
        logic [2:0] m;
        logic [7:0] dir, lat, pcr, een, ev, oe, out, pu, lvl;
    } row_t;
    // Mode, registers, board drive; then expected pins and level read
    row_t rows [6] = '{
        {3'h7, 8'hf0, 8'ha5, 8'h0f, 8'h0f, 8'h06, 8'hf0, 8'ha0, 8'h0f, 8'ha6},
        {3'h7, 8'h00, 8'hff, 8'hf0, 8'h0f, 8'h05, 8'h00, 8'h00, 8'hf0, 8'hf5},
        {3'h2, 8'hff, 8'h81, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h81},
        {3'h6, 8'hc3, 8'h00, 8'hff, 8'hff, 8'h18, 8'hc3, 8'h42, 8'h3c, 8'h18},
        {3'h5, 8'h0f, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h5a, 8'h00, 8'h5f},
        {3'h4, 8'h00, 8'h33, 8'hff, 8'h00, 8'h00, 8'hff, 8'h5a, 8'h00, 8'h5a}
    };
    logic        pclk, presetn, ce, psel, penable, pwrite, sw_standby, hw_standby_n, pready, pslverr, er;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [2:0]  op_mode;
    logic [7:0]  addr_in, pin_in, pin_out, pin_oe, pullup_en, ext_en, ext_val;
    int          miscompares = 0;
    int          checks = 0;

    addr_io_port i_addr_io_port (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .op_mode, .sw_standby, .hw_standby_n, .addr_in, .pin_in, .pin_out,
        .pin_oe, .pullup_en);
    ext_pins i_ext_pins (.pclk, .pin_out, .pin_oe, .pullup_en, .ext_en, .ext_val, .pin_in);

    ////////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    // Waits on pready without assuming a latency
    task apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rchk(input string n, input logic [15:0] idx, input logic [7:0] e);
        apb(0, idx, 8'h00);
        chk(n, e, rd[7:0]);
    endtask
    task test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #20000;
        miscompares++;
        test_done;
    end
    initial begin
        {presetn, psel, penable, pwrite, sw_standby, paddr, pwdata} = 0;
        {ce, hw_standby_n, pstrb, op_mode} = {2'b11, 4'hf, 3'h7};
        {addr_in, ext_en, ext_val} = {8'h5a, 8'hff, 8'h96};
        repeat (2) @(posedge pclk);
        presetn <= 1;
        chk("oe_reset", 8'h00, pin_oe);
        rchk("latch_rst", `IDX_OUTPUT_LATCH, `RST_OUTPUT_LATCH);
        rchk("pcr_rst", `IDX_PULLUP_CTRL, `RST_PULLUP_CTRL);
        rchk("level_rst", `IDX_PIN_LEVEL, 8'h96);
        foreach (rows[i]) begin
            op_mode <= rows[i].m;
            ext_en <= rows[i].een;
            ext_val <= rows[i].ev;
            apb(1, `IDX_PIN_DIRECTION, rows[i].dir);
            apb(1, `IDX_OUTPUT_LATCH, rows[i].lat);
            apb(1, `IDX_PULLUP_CTRL, rows[i].pcr);
            repeat (6) @(posedge pclk);
            #1;
            chk("pin_oe", rows[i].oe, pin_oe);
            chk("pin_out", rows[i].out, pin_out & pin_oe);
            chk("pullup_en", rows[i].pu, pullup_en);
            rchk("level", `IDX_PIN_LEVEL, rows[i].lvl);
            rchk("latch", `IDX_OUTPUT_LATCH, rows[i].lat);
            rchk("pcr", `IDX_PULLUP_CTRL, rows[i].pcr);
            rchk("dir", `IDX_PIN_DIRECTION, `DIR_READ_VALUE);
        end
        apb(1, `IDX_PIN_LEVEL, 8'hff);
        rchk("latch_kept", `IDX_OUTPUT_LATCH, 8'h33);
        apb(0, 16'h0001, 8'h00);
        chk("slverr", 8'h01, {7'h0, er});
        chk("unmapped", 8'h00, rd[7:0]);
        // A setup edge lost to a low clock enable must not return stale data
        fork
            rchk("latch_ce", `IDX_OUTPUT_LATCH, 8'h33);
            begin
                @(posedge pclk);
                ce <= 0;
                @(posedge pclk);
                ce <= 1;
            end
        join
        // Software standby with address hold, then float, then release
        apb(1, `IDX_STANDBY_CTRL, 8'h01);
        sw_standby <= 1;
        repeat (2) @(posedge pclk);
        addr_in <= 8'ha5;
        repeat (3) @(posedge pclk);
        #1;
        chk("hold_out", 8'h5a, pin_out);
        chk("hold_oe", 8'hff, pin_oe);
        apb(1, `IDX_STANDBY_CTRL, 8'h00);
        repeat (2) @(posedge pclk);
        #1;
        chk("float_oe", 8'h00, pin_oe);
        sw_standby <= 0;
        repeat (3) @(posedge pclk);
        #1;
        chk("live_out", 8'ha5, pin_out);
        rchk("latch_sw", `IDX_OUTPUT_LATCH, 8'h33);
        // Hardware standby clears and blocks writes
        op_mode <= 3'h7;
        apb(1, `IDX_PIN_DIRECTION, 8'hf0);
        apb(1, `IDX_PULLUP_CTRL, 8'h0f);
        hw_standby_n <= 0;
        repeat (4) @(posedge pclk);
        apb(1, `IDX_OUTPUT_LATCH, 8'hff);
        #1;
        chk("hw_oe", 8'h00, pin_oe);
        chk("hw_pu", 8'h00, pullup_en);
        hw_standby_n <= 1;
        ext_val <= 8'h3c;
        ext_en <= 8'hff;
        repeat (4) @(posedge pclk);
        rchk("hw_latch", `IDX_OUTPUT_LATCH, 8'h00);
        rchk("hw_pcr", `IDX_PULLUP_CTRL, 8'h00);
        rchk("hw_level", `IDX_PIN_LEVEL, 8'h3c);
        test_done;
    end
endmodule // addr_io_port_test
`default_nettype wire
